/* tpc_pkg.sv */
// package: register map, field layouts and shared types of the timer block
`default_nettype none
package tpc_pkg;
  // channel count and word widths
  localparam int NCH = 2;
  localparam int DIV_W = 7;

  // register byte offsets
  localparam logic [7:0] A_SC = 8'h00;
  localparam logic [7:0] A_CNT = 8'h04;
  localparam logic [7:0] A_MOD = 8'h08;
  localparam logic [7:0] A_PU = 8'h0c;
  localparam logic [7:0] A_CH0 = 8'h10;
  localparam logic [7:0] A_CH_STRIDE = 8'h08;

  // field positions inside written data
  localparam int SC_FLAG = 7;
  localparam int CS_FLAG = 7;

  // reset values and the full-range count
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hffff;

  // clock source select, in register order: off, bus, fixed, external
  typedef enum logic [1:0] {CLK_OFF, CLK_BUS, CLK_FIX, CLK_EXT} tpc_clks_e;

  // channel mode: capture, compare, edge pwm (two codes)
  typedef enum logic [1:0] {MODE_CAP, MODE_CMP, MODE_PWM, MODE_PWM_B} tpc_mode_e;

  // timer status and control byte
  typedef struct packed {
    logic flag;
    logic ie;
    logic center_aligned_pwm_mode;
    tpc_clks_e clks;
    logic [2:0] ps;
  } tpc_sc_s;

  // channel status and control byte
  typedef struct packed {
    logic flag;
    logic ie;
    tpc_mode_e mode;
    logic [1:0] els;
    logic [1:0] rsv;
  } tpc_cs_s;

  localparam tpc_sc_s SC_RST = '0;
  localparam tpc_cs_s CS_RST = '0;
endpackage : tpc_pkg
`default_nettype wire

/* tpc_sync.sv */
// module: two-flop synchroniser for a group of pin levels
`default_nettype none
module tpc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tpc_sync_s;

  tpc_sync_s s_q;
  tpc_sync_s s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule : tpc_sync
`default_nettype wire

/* tpc_prescale.sv */
// module: clock source select and divide-by-2^n prescaler, one-cycle tick out
`default_nettype none
module tpc_prescale (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // selection
  input wire tpc_pkg::tpc_clks_e clks,
  input wire logic [2:0] ps,
  // synchronised source levels
  input wire logic fix_s,
  input wire logic ext_s,
  // counter advance
  output logic tick
);
  typedef struct packed {
    logic [tpc_pkg::DIV_W-1:0] div;
    logic fprev;
    logic eprev;
    logic tick;
  } tpc_pre_s;

  tpc_pre_s s_q;
  tpc_pre_s s_d;
  logic ev;
  logic [tpc_pkg::DIV_W-1:0] mask;

  // slow sources count on rising edges only, so they must stay below half the bus rate
  always_comb begin
    s_d = s_q;
    s_d.fprev = fix_s;
    s_d.eprev = ext_s;
    mask = tpc_pkg::DIV_W'((8'h01 << ps) - 8'h01);
    case (clks)
      tpc_pkg::CLK_BUS: ev = 1'b1;
      tpc_pkg::CLK_FIX: ev = fix_s && !s_q.fprev;
      tpc_pkg::CLK_EXT: ev = ext_s && !s_q.eprev;
      default: ev = 1'b0;
    endcase
    s_d.tick = ev && ((s_q.div & mask) == mask);
    if (clks == tpc_pkg::CLK_OFF) begin
      s_d.div = '0;
    end else if (ev) begin
      s_d.div = tpc_pkg::DIV_W'(s_q.div + 7'h01);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : tpc_prescale
`default_nettype wire

/* tpc_timer.sv */
// module: 16-bit timer with capture, compare and pwm channels behind apb
//
// Overview of operation
// - prescaler ahead of counter divides by 1, 2, 4 up to 128
// - 16-bit counter counts up, or up and down in center-aligned mode
// - a 16-bit modulus bounds the counter range
// - modulus of all zeros or all ones lets the counter run full range
// - reading the counter returns it and never disturbs counting
// - any write to the counter clears it, whatever the data
// - clock source code one-one feeds the prescaler from the external pin
// - external clock passes a bus-clocked synchroniser first
// - a channel whose pin is the clock input never uses that pin
// - each channel owns exactly one pin shared with a port bit
// - timer-owned pin ignores port data and direction; otherwise port rules
// - after reset timer off, pins port inputs, pull-ups off
// - pull-up may be enabled on any pin used as timer input
// - each channel independently capture, compare or edge pwm
// - center-aligned pwm selected once for all channels
// - capture latches count on rising, falling or either edge
// - compare match sets, clears or toggles the pin
// - pwm outputs have selectable polarity
// - one interrupt per channel plus one overflow interrupt
// - clock from bus clock, fixed system clock or external pin
// - clock code 00 off, 01 bus, 10 fixed, 11 external
// - overflow flag on wrap to zero, or on step down from top
// - flag clears by read-while-set then write zero; overflow restarts
`default_nettype none
module tpc_timer #(
  parameter int NCH = tpc_pkg::NCH,
  parameter int EXT_CH = 0,
  parameter bit EXT_SHARED = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source pins
  input wire logic fixed_system_clock,
  input wire logic external_timer_clock_pin,
  // channel pins and the port bits sharing them
  input wire logic [NCH-1:0] channel_io_pin_in,
  output logic [NCH-1:0] channel_io_pin_out,
  output logic [NCH-1:0] channel_io_pin_oe,
  output logic [NCH-1:0] pin_pullup_en,
  input wire logic [NCH-1:0] port_data,
  input wire logic [NCH-1:0] port_dir,
  // interrupt requests
  output logic overflow_irq,
  output logic [NCH-1:0] channel_irq
);
  typedef struct packed {
    tpc_pkg::tpc_sc_s sc;
    logic tof_arm;
    logic [15:0] cnt;
    logic down;
    logic [15:0] modv;
    tpc_pkg::tpc_cs_s [NCH-1:0] cs;
    logic [NCH-1:0] ch_arm;
    logic [NCH-1:0][15:0] val;
    logic [NCH-1:0][15:0] vbuf;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] oc_lvl;
    logic [NCH-1:0] pu;
    logic [NCH-1:0] pin_out;
    logic [NCH-1:0] pin_oe;
    logic [NCH-1:0] pu_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ovf_irq;
    logic [NCH-1:0] ch_irq;
  } tpc_state_s;

  tpc_state_s s_q;
  tpc_state_s s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic tick;
  logic fix_s;
  logic ext_s;
  logic [NCH-1:0] pin_s;
  logic wr;
  logic rd;
  logic sel_sc;
  logic sel_cnt;
  logic sel_mod;
  logic sel_pu;
  logic sel_cs;
  logic sel_cv;
  logic [4:0] ch_sel;
  logic ovf;
  logic [15:0] top;
  logic [NCH-1:0] own;
  logic [NCH-1:0] pwm;
  logic [NCH-1:0] lvl;

  // channel slot of an address, and whether it falls in the channel window
  function automatic logic [4:0] ch_of(input logic [7:0] a);
    logic [7:0] off;
    off = 8'(a - tpc_pkg::A_CH0);
    return off[7:3];
  endfunction : ch_of

  function automatic logic in_ch(input logic [7:0] a);
    return (a >= tpc_pkg::A_CH0) && (ch_of(a) < 5'(NCH)) && (a[1:0] == 2'b00);
  endfunction : in_ch

  // reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins from outside the clock domain
  tpc_sync #(.W(NCH + 2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({external_timer_clock_pin, fixed_system_clock, channel_io_pin_in}),
    .q({ext_s, fix_s, pin_s})
  );

  tpc_prescale u_pre (
    .clock(clock),
    .rst_n(rst_n),
    .clks(s_q.sc.clks),
    .ps(s_q.sc.ps),
    .fix_s(fix_s),
    .ext_s(ext_s),
    .tick(tick)
  );

  always_comb begin
    s_d = s_q;
    // apb: one wait state so read data comes from a flip-flop
    wr = psel && penable && s_q.pready && pwrite;
    rd = psel && penable && s_q.pready && !pwrite;
    sel_sc = 1'b0;
    sel_cnt = 1'b0;
    sel_mod = 1'b0;
    sel_pu = 1'b0;
    sel_cs = 1'b0;
    sel_cv = 1'b0;
    ch_sel = ch_of(paddr);
    if (paddr == tpc_pkg::A_SC) begin
      sel_sc = 1'b1;
    end else if (paddr == tpc_pkg::A_CNT) begin
      sel_cnt = 1'b1;
    end else if (paddr == tpc_pkg::A_MOD) begin
      sel_mod = 1'b1;
    end else if (paddr == tpc_pkg::A_PU) begin
      sel_pu = 1'b1;
    end else if (in_ch(paddr)) begin
      sel_cs = !paddr[2];
      sel_cv = paddr[2];
    end
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata = '0;
    if (s_d.pready) begin
      s_d.pslverr = !(sel_sc || sel_cnt || sel_mod || sel_pu || sel_cs || sel_cv);
      if (sel_sc) begin
        s_d.prdata = {24'h000000, s_q.sc};
      end else if (sel_cnt) begin
        s_d.prdata = {16'h0000, s_q.cnt};
      end else if (sel_mod) begin
        s_d.prdata = {16'h0000, s_q.modv};
      end else if (sel_pu) begin
        s_d.prdata = 32'(s_q.pu);
      end else if (sel_cs) begin
        s_d.prdata = {24'h000000, s_q.cs[ch_sel]};
      end else if (sel_cv) begin
        s_d.prdata = {16'h0000, s_q.val[ch_sel]};
      end
    end

    // counter: up with wrap, or up/down in center mode
    top = (s_q.modv == tpc_pkg::MOD_RST || s_q.modv == tpc_pkg::CNT_FULL) ?
      tpc_pkg::CNT_FULL : s_q.modv;
    ovf = 1'b0;
    if (tick) begin
      if (!s_q.sc.center_aligned_pwm_mode) begin
        if (s_q.cnt == top) begin
          s_d.cnt = tpc_pkg::CNT_RST;
          ovf = 1'b1;
        end else begin
          s_d.cnt = 16'(s_q.cnt + 16'h0001);
        end
      end else if (!s_q.down) begin
        if (s_q.cnt >= top) begin
          s_d.down = 1'b1;
          s_d.cnt = 16'(s_q.cnt - 16'h0001);
          ovf = 1'b1;
        end else begin
          s_d.cnt = 16'(s_q.cnt + 16'h0001);
        end
      end else if (s_q.cnt == 16'h0000) begin
        s_d.down = 1'b0;
        s_d.cnt = 16'h0001;
      end else begin
        s_d.cnt = 16'(s_q.cnt - 16'h0001);
      end
    end
    if (wr && sel_cnt) begin
      s_d.cnt = tpc_pkg::CNT_RST;
      s_d.down = 1'b0;
    end

    // control writes and overflow flag clear sequence
    if (wr && sel_sc) begin
      s_d.sc.ie = pwdata[6];
      s_d.sc.center_aligned_pwm_mode = pwdata[5];
      s_d.sc.clks = tpc_pkg::tpc_clks_e'(pwdata[4:3]);
      s_d.sc.ps = pwdata[2:0];
      if (s_q.tof_arm && !pwdata[tpc_pkg::SC_FLAG]) begin
        s_d.sc.flag = 1'b0;
        s_d.tof_arm = 1'b0;
      end
    end
    if (rd && sel_sc && s_q.sc.flag) begin
      s_d.tof_arm = 1'b1;
    end
    // a new overflow beats a clear in the same cycle and restarts the sequence
    if (ovf) begin
      s_d.sc.flag = 1'b1;
      s_d.tof_arm = 1'b0;
    end
    if (wr && sel_mod) begin
      s_d.modv = pwdata[15:0];
    end
    if (wr && sel_pu) begin
      s_d.pu = pwdata[NCH-1:0];
    end

    // channels
    for (int i = 0; i < NCH; i++) begin
      pwm[i] = s_q.sc.center_aligned_pwm_mode || s_q.cs[i].mode[1];
      own[i] = (s_q.sc.clks != tpc_pkg::CLK_OFF) && (s_q.cs[i].els != 2'b00)
        && !(EXT_SHARED && i == EXT_CH && s_q.sc.clks == tpc_pkg::CLK_EXT);
      s_d.pin_prev[i] = pin_s[i];
      if (wr && sel_cs && ch_sel == 5'(i)) begin
        s_d.cs[i].ie = pwdata[6];
        s_d.cs[i].mode = tpc_pkg::tpc_mode_e'(pwdata[5:4]);
        s_d.cs[i].els = pwdata[3:2];
        if (s_q.ch_arm[i] && !pwdata[tpc_pkg::CS_FLAG]) begin
          s_d.cs[i].flag = 1'b0;
          s_d.ch_arm[i] = 1'b0;
        end
      end
      if (rd && sel_cs && ch_sel == 5'(i) && s_q.cs[i].flag) begin
        s_d.ch_arm[i] = 1'b1;
      end
      // pwm writes go to the buffer; other modes load the active value at once
      if (wr && sel_cv && ch_sel == 5'(i)) begin
        s_d.vbuf[i] = pwdata[15:0];
        if (!pwm[i]) begin
          s_d.val[i] = pwdata[15:0];
        end
      end
      if (pwm[i] && ovf) begin
        s_d.val[i] = s_q.vbuf[i];
      end
      if (pwm[i]) begin
        // active while below the value; low bit of the edge field inverts
        lvl[i] = (s_d.cnt < s_q.val[i]) ^ s_q.cs[i].els[0];
        if (tick && s_d.cnt == s_q.val[i]) begin
          s_d.cs[i].flag = 1'b1;
          s_d.ch_arm[i] = 1'b0;
        end
      end else if (s_q.cs[i].mode == tpc_pkg::MODE_CMP) begin
        // compare still flags with no pin, usable as a software timer
        if (tick && s_d.cnt == s_q.val[i]) begin
          s_d.cs[i].flag = 1'b1;
          s_d.ch_arm[i] = 1'b0;
          case (s_q.cs[i].els)
            2'b01: s_d.oc_lvl[i] = !s_q.oc_lvl[i];
            2'b10: s_d.oc_lvl[i] = 1'b0;
            2'b11: s_d.oc_lvl[i] = 1'b1;
            default: s_d.oc_lvl[i] = s_q.oc_lvl[i];
          endcase
        end
        lvl[i] = s_d.oc_lvl[i];
      end else begin
        lvl[i] = 1'b0;
        if (own[i] && ((s_q.cs[i].els[0] && pin_s[i] && !s_q.pin_prev[i])
            || (s_q.cs[i].els[1] && !pin_s[i] && s_q.pin_prev[i]))) begin
          s_d.val[i] = s_q.cnt;
          s_d.cs[i].flag = 1'b1;
          s_d.ch_arm[i] = 1'b0;
        end
      end
      // one pin per channel: when owned the timer drives it, or keeps it an input for capture; else the port bit does
      if (own[i]) begin
        s_d.pin_oe[i] = s_q.cs[i].mode != tpc_pkg::MODE_CAP || s_q.sc.center_aligned_pwm_mode;
        s_d.pin_out[i] = lvl[i];
      end else begin
        s_d.pin_oe[i] = port_dir[i];
        s_d.pin_out[i] = port_data[i];
      end
      s_d.pu_out[i] = s_q.pu[i] && ((own[i] && !s_d.pin_oe[i])
        || (EXT_SHARED && i == EXT_CH && s_q.sc.clks == tpc_pkg::CLK_EXT));
      s_d.ch_irq[i] = s_d.cs[i].flag && s_d.cs[i].ie;
    end
    s_d.ovf_irq = s_d.sc.flag && s_d.sc.ie;
  end

  // everything, including pins, starts idle: timer off, pins port inputs, pull-ups off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign channel_io_pin_out = s_q.pin_out;
  assign channel_io_pin_oe = s_q.pin_oe;
  assign pin_pullup_en = s_q.pu_out;
  assign overflow_irq = s_q.ovf_irq;
  assign channel_irq = s_q.ch_irq;

  // checks on counter, flag sequence and pin ownership
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd_flag;
    rd && sel_sc && s_q.sc.flag;
  endsequence
  sequence s_wr_zero;
    wr && sel_sc && !pwdata[tpc_pkg::SC_FLAG] && !ovf && s_q.tof_arm;
  endsequence

  a_cnt_write_clr: assert property (
    wr && sel_cnt |=> s_q.cnt == 16'h0000 && !s_q.down)
    else $error("counter not cleared by write");
  a_cnt_read_keep: assert property (
    rd && sel_cnt && !tick |=> $stable(s_q.cnt))
    else $error("counter read disturbed count");
  a_free_wrap: assert property (
    tick && !s_q.sc.center_aligned_pwm_mode && s_q.modv == 16'h0000 && s_q.cnt == 16'hffff
    && !(wr && sel_cnt) |=> s_q.cnt == 16'h0000 && s_q.sc.flag)
    else $error("free-running wrap wrong");
  a_mod_wrap: assert property (
    tick && !s_q.sc.center_aligned_pwm_mode && s_q.modv != 16'h0000 && s_q.modv != 16'hffff
    && s_q.cnt == s_q.modv && !(wr && sel_cnt) |=> s_q.cnt == 16'h0000)
    else $error("modulus wrap wrong");
  a_center_turn: assert property (
    tick && s_q.sc.center_aligned_pwm_mode && !s_q.down && s_q.cnt == top && !(wr && sel_cnt)
    |=> s_q.down && s_q.sc.flag && s_q.cnt == 16'($past(s_q.cnt) - 16'h0001))
    else $error("center turn or flag wrong");
  a_clk_off_hold: assert property (
    s_q.sc.clks == tpc_pkg::CLK_OFF ##1 !(wr && sel_cnt) |=> $stable(s_q.cnt))
    else $error("counter moved while disabled");
  a_flag_clear: assert property (
    s_rd_flag ##[2:8] s_wr_zero |=> !s_q.sc.flag)
    else $error("overflow flag clear sequence failed");
  a_flag_set_wins: assert property (
    ovf |=> s_q.sc.flag && !s_q.tof_arm ##1 s_q.sc.flag)
    else $error("overflow lost to clear");
  a_ext_deny: assert property (
    EXT_SHARED && s_q.sc.clks == tpc_pkg::CLK_EXT
    |=> channel_io_pin_oe[EXT_CH] == $past(port_dir[EXT_CH]))
    else $error("clock pin taken by its channel");
endmodule : tpc_timer
`default_nettype wire

/* tpc_pins_model.sv */
// pin side model: port pin wiring, fixed clock and external clock source
`default_nettype none
module tpc_pins_model #(
  parameter int NCH = 2
) (
  // clock
  input wire logic clock,
  // commands from the bench
  input wire logic ext_on,
  input wire logic [NCH-1:0] drv_en,
  input wire logic [NCH-1:0] drv_lvl,
  // design pin side
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] pin_oe,
  input wire logic [NCH-1:0] pull_en,
  // resolved levels
  output logic [NCH-1:0] pin_lvl,
  output logic fix_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q = 3'h0;
  logic flt_q = 1'b0;

  // free divider: fixed clock at an eighth, external at a quarter of bus rate
  always @(posedge clock) begin
    div_q <= div_q + 3'h1;
    flt_q <= ~flt_q;
  end
  assign fix_clk = div_q[2];

  // wire level; an undriven pin without pull-up keeps changing, never a stale value
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (i == 0 && ext_on) begin
        pin_lvl[i] = div_q[1];
      end else if (drv_en[i]) begin
        pin_lvl[i] = drv_lvl[i];
      end else begin
        pin_lvl[i] = pull_en[i] | flt_q;
      end
    end
  end
endmodule : tpc_pins_model
`default_nettype wire

/* tpc_timer_tb.sv */
// testbench: apb stimulus, count rates, flags, compare, pwm and capture pins
`default_nettype none
module tpc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = tpc_pkg::NCH;
  localparam logic [7:0] SC = tpc_pkg::A_SC;
  localparam logic [7:0] CNT = tpc_pkg::A_CNT;
  localparam logic [7:0] MD = tpc_pkg::A_MOD;
  localparam logic [7:0] C0 = tpc_pkg::A_CH0;
  localparam logic [7:0] C1 = C0 + tpc_pkg::A_CH_STRIDE;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, ovf_irq, ext_on, fix_clk, err;
  logic [7:0] paddr;
  logic [15:0] dl;
  logic [31:0] pwdata, prdata, rdv, a, b, e;
  logic [NCH-1:0] pin_out, pin_oe, pull_en, port_data, port_dir, ch_irq, pin_lvl;
  logic [NCH-1:0] drv_en, drv_lvl;
  int fails = 0, checked = 0, cycles = 0, d, hcnt;
  // rate rows: control byte beside counts expected in 256 clocks
  logic [7:0] row_sc [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
    8'h10, 8'h18, 8'h00};
  int row_rate [11] = '{256, 128, 64, 32, 16, 8, 4, 2, 32, 64, 0};

  tpc_timer uut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fixed_system_clock(fix_clk), .external_timer_clock_pin(pin_lvl[0]),
    .channel_io_pin_in(pin_lvl), .channel_io_pin_out(pin_out), .channel_io_pin_oe(pin_oe),
    .pin_pullup_en(pull_en), .port_data(port_data), .port_dir(port_dir),
    .overflow_irq(ovf_irq), .channel_irq(ch_irq));
  tpc_pins_model #(.NCH(NCH)) pins (.clock(clock), .ext_on(ext_on), .drv_en(drv_en),
    .drv_lvl(drv_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .pin_lvl(pin_lvl), .fix_clk(fix_clk));

  // bus clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer, then one idle edge so the next setup never clashes
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt);
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // high cycles of channel 1 pin over n clocks
  task automatic hi(input int n);
    hcnt = 0;
    repeat (n) begin
      @(posedge clock);
      if (pin_out[1] === 1'b1) hcnt++;
    end
  endtask : hi

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_data = '0;
    port_dir = '0;
    ext_on = 1'b0;
    drv_en = 2'h1;
    drv_lvl = '0;
    cyc(12);
    chk("reset oe", 0, pin_oe);
    chk("reset pull", 0, pull_en);
    rst_b <= 1'b1;
    cyc(3);
    rd(SC);
    chk("reset control", 0, rdv);
    rd(CNT);
    chk("idle count", 0, rdv);
    rd(8'h40);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rdv);
    // rate rows; channel 0 stays 00 while its pin clocks the counter
    for (int i = 0; i < 11; i++) begin
      ext_on <= (row_sc[i][4:3] == 2'b11);
      wr(SC, 32'(row_sc[i]));
      rd(CNT);
      a = rdv;
      cyc(252);
      rd(CNT);
      dl = rdv[15:0] - a[15:0];
      d = int'(dl) - row_rate[i];
      chk("count rate", 1, d >= -1 && d <= 1);
    end
    // channel 0 asks for its pin while it clocks the timer
    ext_on <= 1'b1;
    wr(SC, 32'h18);
    wr(tpc_pkg::A_PU, 32'h1);
    wr(C0, 32'h1c);
    cyc(3);
    chk("clock pin oe", 0, pin_oe[0]);
    chk("clock pin pull", 1, pull_en[0]);
    wr(C0, 32'h0);
    ext_on <= 1'b0;
    wr(SC, 32'h08);
    rd(CNT);
    a = rdv;
    rd(CNT);
    chk("read gap", a + 4, rdv);
    wr(CNT, 32'hbeef);
    rd(CNT);
    chk("count cleared", 1, rdv < 8);
    // modulus bound and overflow flag clearing
    wr(MD, 32'h3);
    // restart below the new modulus, else the count runs to the top first
    wr(CNT, 32'h0);
    wr(SC, 32'h48);
    cyc(20);
    rd(CNT);
    chk("count bound", 1, rdv <= 3);
    wr(SC, 32'h40);
    rd(SC);
    chk("flag kept", 32'hc0, rdv);
    chk("overflow irq", 1, ovf_irq);
    wr(SC, 32'h40);
    rd(SC);
    chk("flag cleared", 32'h40, rdv);
    chk("irq cleared", 0, ovf_irq);
    // center aligned: counts down too, never past the modulus
    wr(MD, 32'h8);
    wr(SC, 32'h28);
    a = 0;
    e = 0;
    b = 0;
    for (int i = 0; i < 12; i++) begin
      rd(CNT);
      if (rdv[15:0] < a[15:0]) e = 1;
      if (rdv > 8) b = 1;
      a = rdv;
    end
    chk("down count", 1, e);
    chk("center bound", 0, b);
    rd(SC);
    chk("center flag", 1, rdv[7]);
    // compare on channel 1 while the port asks for the opposite
    port_dir <= '1;
    wr(MD, 32'hf);
    wr(C1, 32'h5c);
    wr(C1 + 4, 32'h5);
    wr(SC, 32'h08);
    cyc(40);
    chk("cmp set", 2'b11, {pin_oe[1], pin_out[1]});
    chk("channel irq", 1, ch_irq[1]);
    wr(C1, 32'h58);
    cyc(40);
    chk("cmp clear", 2'b10, {pin_oe[1], pin_out[1]});
    wr(C1, 32'h54);
    cyc(5);
    a[0] = pin_out[1];
    cyc(16);
    chk("cmp toggle", 1, pin_out[1] !== a[0]);
    port_data <= '1;
    wr(C1, 32'h0);
    cyc(3);
    chk("port owns pin", 2'b11, {pin_oe[1], pin_out[1]});
    port_dir <= '0;
    // edge pwm duty, polarity and buffered value
    wr(C1, 32'h28);
    wr(C1 + 4, 32'h4);
    cyc(40);
    hi(32);
    chk("pwm high", 8, hcnt);
    wr(C1, 32'h24);
    cyc(5);
    hi(32);
    chk("pwm low true", 24, hcnt);
    wr(C1, 32'h28);
    wr(SC, 32'h0f);
    wr(CNT, 32'h0);
    wr(C1 + 4, 32'h0);
    cyc(3);
    chk("pwm held", 1, pin_out[1]);
    rd(C1 + 4);
    chk("active value", 4, rdv);
    wr(SC, 32'h08);
    cyc(40);
    hi(32);
    chk("pwm new value", 0, hcnt);
    // capture on channel 0: rising, falling, both
    wr(MD, 32'h0);
    wr(tpc_pkg::A_PU, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(C0, 32'(m << 2));
      cyc(8);
      rd(C0 + 4);
      a = rdv;
      drv_lvl[0] <= 1'b1;
      cyc(8);
      rd(C0 + 4);
      b = rdv;
      drv_lvl[0] <= 1'b0;
      cyc(8);
      rd(C0 + 4);
      chk("rise capture", m & 1, b !== a);
      chk("fall capture", (m >> 1) & 1, rdv !== b);
    end
    chk("capture oe", 0, pin_oe[0]);
    chk("capture pull", 1, pull_en[0]);
    results();
  end
endmodule : tpc_timer_tb
`default_nettype wire
